// ---- core/smci_pkg.sv ----
// Constants, field layout and state type for the static memory controller.
// Assumes one 100 MHz clock; test clock muxing is done outside the block.
//
// Overview of operation
// - Act only on the region whose select, registers or memory, is high.
// - Wait response stays high while another cycle is needed.
// - Error response high reports a failed transfer, low a good one.
// - Retract is error and last responses raised together.
// - Last response high ends the ongoing burst sequence.
// - Master drives system data on writes, controller drives it on reads.
// - Test takeover high claims the external bus as a 32-bit test bus.
// - Test data-in enable low drives external input data onto system data.
// - Test data-out enable low drives the latched system data out.
// - Test latch loads system data on each clock edge while its enable is low, holds when high.
// - Endian select 1 means big-endian lanes, 0 means little-endian.
// - Scan mode high leaves every tristate output undriven.
// - Request the shared external bus; use it only while granted.
// - Four active-low lane drives, lane n covers external byte n.
// - One chip select per bank, polarity set per bank.
// - Shared output enable and write enable are active-low strobes.
// - Four active-low byte-lane selects, bit n selects byte n.
// - External wait polarity follows the accessed bank's setting.
// - 23-bit external address derived from the 26-bit system address.
// - Enabled external wait extends access until release or count expiry.
// - On reads lane selects all high if read-lane bit 0, all low if 1.

package smci_pkg;

  localparam int NUM_BANKS = 8;
  localparam int SYS_ADDR_W = 26;
  localparam int EXT_ADDR_W = 23;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int BANK_LSB = 23;
  localparam int REG_IDX_LSB = 2;
  localparam int REG_IDX_W = 3;
  localparam int REG_SPAN_LSB = 5;

  // Bank configuration word
  localparam logic [31:0] CFG_RESET = 32'h1000FBEF;
  localparam logic [31:0] CFG_MASK = 32'h3FE0FFEF;
  localparam int BIT_BM = 27;
  localparam int BIT_WP = 26;
  localparam int BIT_WPERR = 25;
  localparam int BIT_BUSERR = 24;
  localparam int BIT_CSPOL = 23;
  localparam int BIT_EXT_WAIT_ENABLE = 22;
  localparam int BIT_EXT_WAIT_POLARITY = 21;
  localparam int WST2_LSB = 11;
  localparam int BIT_READ_LANE_ASSERT = 10;
  localparam int WST1_LSB = 5;
  localparam int IDCY_LSB = 0;
  localparam int WST_W = 5;
  localparam int IDCY_W = 4;

  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [LANES-1:0] LANES_ALL = 4'hF;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [LANES-1:0] LANE_LOW = 4'h1;
  localparam logic [LANES-1:0] LANE_HIGH = 4'h8;
  localparam logic [LANES-1:0] HALF_LOW = 4'h3;
  localparam logic [LANES-1:0] HALF_HIGH = 4'hC;

  // Cycles a memory request waits for the bus grant before retracting
  localparam logic [7:0] GRANT_WAIT = 8'h40;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ONE = 3'b001,
    ST_REQ = 3'b010,
    ST_TURN = 3'b011,
    ST_ACC = 3'b100
  } smci_state_t;

endpackage

// ---- core/smci_core.sv ----
// Static memory controller core: bus slave, bank registers, external pins.
// Assumes bus inputs synchronous to clk; pads resolve the enables.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns

module smci_core #(
  parameter logic [7:0] GRANT_WAIT = smci_pkg::GRANT_WAIT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [smci_pkg::SYS_ADDR_W-1:0] busAddr,
  input wire logic busWrite,
  input wire logic [1:0] busSize,
  input wire logic cfgRegionSelect,
  input wire logic memRegionSelect,
  input wire logic [smci_pkg::DATA_W-1:0] busDataIn,
  output logic [smci_pkg::DATA_W-1:0] busDataOut,
  output logic busDataOe,
  output logic busWait,
  output logic busError,
  output logic busLast,
  input wire logic testTakeover,
  input wire logic testDinEn_n,
  input wire logic testDoutEn_n,
  input wire logic testDoutLatchEn_n,
  input wire logic endianSelect,
  input wire logic scanTestMode,
  output logic extBusRequest,
  input wire logic extBusGrant,
  input wire logic [smci_pkg::DATA_W-1:0] extDataIn,
  input wire logic extWaitIn,
  output logic [smci_pkg::DATA_W-1:0] extDataOut,
  output logic [smci_pkg::EXT_ADDR_W-1:0] extAddress,
  output logic [smci_pkg::LANES-1:0] extLaneDrive_n,
  output logic [smci_pkg::NUM_BANKS-1:0] bankChipSelect,
  output logic extOutputEnable_n,
  output logic extWriteEnable_n,
  output logic [smci_pkg::LANES-1:0] extByteLane_n
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  smci_pkg::smci_state_t state_reg, state_next;
  logic [31:0] bankCfg_reg [smci_pkg::NUM_BANKS];
  logic [smci_pkg::SYS_ADDR_W-1:0] reqAddr_reg;
  logic [smci_pkg::DATA_W-1:0] reqData_reg, testLatch_reg;
  logic [1:0] reqSize_reg;
  logic reqWrite_reg, reqCfg_reg, reqWpErr_reg, reqBig_reg;
  logic lastWasRead_reg, waitSeen_reg;
  logic [smci_pkg::WST_W-1:0] cnt_reg, cnt_next;
  logic [7:0] grantCnt_reg;
  logic [31:0] cfgSel;
  logic [smci_pkg::REG_IDX_W-1:0] regIdx;
  logic regValid, waitAsserted, cntZero, accept, wpErr, retract, accDone;
  logic needTurn, accNext;
  logic [smci_pkg::LANES-1:0] laneSel;
  logic [smci_pkg::NUM_BANKS-1:0] csActive, csPolVec;

  // Byte lanes touched by a transfer of the given size and offset
  function automatic logic [smci_pkg::LANES-1:0] laneMask(
    input logic [1:0] size, input logic [1:0] ofs, input logic big);
    logic [smci_pkg::LANES-1:0] m;
    m = smci_pkg::LANES_ALL;
    if (size == smci_pkg::SIZE_BYTE) begin
      m = big ? (smci_pkg::LANE_HIGH >> ofs) : (smci_pkg::LANE_LOW << ofs);
    end else if (size == smci_pkg::SIZE_HALF) begin
      m = (ofs[1] ^ big) ? smci_pkg::HALF_HIGH : smci_pkg::HALF_LOW;
    end
    return m;
  endfunction

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  always_comb begin
    cfgSel = bankCfg_reg[reqAddr_reg[smci_pkg::SYS_ADDR_W-1:smci_pkg::BANK_LSB]];
    regIdx = busAddr[smci_pkg::REG_IDX_LSB +: smci_pkg::REG_IDX_W];
    regValid = (busAddr[smci_pkg::SYS_ADDR_W-1:smci_pkg::REG_SPAN_LSB] == '0);
    waitAsserted = (extWaitIn == cfgSel[smci_pkg::BIT_EXT_WAIT_POLARITY]);
    cntZero = (cnt_reg == '0);
    accept = (state_reg == smci_pkg::ST_IDLE) && !testTakeover
      && (cfgRegionSelect || memRegionSelect);
    wpErr = !cfgRegionSelect && busWrite
      && bankCfg_reg[busAddr[smci_pkg::SYS_ADDR_W-1:smci_pkg::BANK_LSB]]
        [smci_pkg::BIT_WP];
    retract = (state_reg == smci_pkg::ST_REQ) && !extBusGrant
      && (grantCnt_reg == GRANT_WAIT);
    // release or count expiry ends access
    accDone = (state_reg == smci_pkg::ST_ACC) && extBusGrant && (cntZero
      || (cfgSel[smci_pkg::BIT_EXT_WAIT_ENABLE] && waitSeen_reg && !waitAsserted));
    needTurn = (reqWrite_reg == lastWasRead_reg);
    laneSel = laneMask(reqSize_reg, reqAddr_reg[1:0], reqBig_reg);
    for (int b = 0; b < smci_pkg::NUM_BANKS; b++) begin
      csPolVec[b] = bankCfg_reg[b][smci_pkg::BIT_CSPOL];
    end
  end

  // ----------------------------------------
  // Transfer sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      smci_pkg::ST_IDLE: begin
        if (accept) begin
          state_next = (cfgRegionSelect || wpErr) ? smci_pkg::ST_ONE
            : smci_pkg::ST_REQ;
        end
      end
      smci_pkg::ST_ONE: begin
        state_next = smci_pkg::ST_IDLE;
      end
      smci_pkg::ST_REQ: begin
        if (extBusGrant) begin
          state_next = smci_pkg::ST_TURN;
          cnt_next = needTurn ? smci_pkg::WST_W'(cfgSel[smci_pkg::IDCY_LSB +:
            smci_pkg::IDCY_W]) : '0;
        end else if (retract) begin
          state_next = smci_pkg::ST_IDLE;
        end
      end
      smci_pkg::ST_TURN: begin
        // losing the grant returns to the request state
        if (!extBusGrant) begin
          state_next = smci_pkg::ST_REQ;
        end else if (cntZero) begin
          state_next = smci_pkg::ST_ACC;
          cnt_next = reqWrite_reg
            ? cfgSel[smci_pkg::WST2_LSB +: smci_pkg::WST_W]
            : cfgSel[smci_pkg::WST1_LSB +: smci_pkg::WST_W];
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      smci_pkg::ST_ACC: begin
        if (!extBusGrant) begin
          state_next = smci_pkg::ST_REQ;
        end else if (accDone) begin
          state_next = smci_pkg::ST_IDLE;
        end else if (!cntZero) begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: begin
        state_next = smci_pkg::ST_IDLE;
      end
    endcase
    accNext = (state_next == smci_pkg::ST_ACC);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= smci_pkg::ST_IDLE;
      cnt_reg <= '0;
      grantCnt_reg <= '0;
      waitSeen_reg <= 1'b0;
      lastWasRead_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      grantCnt_reg <= (state_reg == smci_pkg::ST_REQ && !extBusGrant)
        ? grantCnt_reg + 1'b1 : '0;
      if (state_reg != smci_pkg::ST_ACC) begin
        waitSeen_reg <= 1'b0;
      end else if (cfgSel[smci_pkg::BIT_EXT_WAIT_ENABLE] && waitAsserted) begin
        // wait seen, now hold for release
        waitSeen_reg <= 1'b1;
      end
      if (accDone) begin
        lastWasRead_reg <= !reqWrite_reg;
      end
    end
  end

  // Request capture; direction and size sampled with the address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reqAddr_reg <= '0;
      reqData_reg <= '0;
      reqSize_reg <= '0;
      reqWrite_reg <= 1'b0;
      reqCfg_reg <= 1'b0;
      reqWpErr_reg <= 1'b0;
      reqBig_reg <= 1'b0;
    end else if (accept) begin
      reqAddr_reg <= busAddr;
      reqData_reg <= busDataIn;
      reqSize_reg <= busSize;
      reqWrite_reg <= busWrite;
      reqCfg_reg <= cfgRegionSelect;
      reqWpErr_reg <= wpErr;
      reqBig_reg <= endianSelect;
    end
  end

  // ----------------------------------------
  // Bank configuration registers
  // ----------------------------------------
  logic [smci_pkg::REG_IDX_W-1:0] reqIdx;
  logic reqRegValid;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reqIdx <= '0;
      reqRegValid <= 1'b0;
    end else if (accept) begin
      reqIdx <= regIdx;
      reqRegValid <= regValid;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int b = 0; b < smci_pkg::NUM_BANKS; b++) begin
        bankCfg_reg[b] <= smci_pkg::CFG_RESET;
      end
    end else begin
      for (int b = 0; b < smci_pkg::NUM_BANKS; b++) begin
        if (state_reg == smci_pkg::ST_ONE && reqCfg_reg && reqWrite_reg
            && reqRegValid && reqIdx == b) begin
          // Status flags are write-one-to-clear, not stored
          bankCfg_reg[b] <= (reqData_reg & smci_pkg::CFG_MASK
            & ~(32'h1 << smci_pkg::BIT_WPERR) & ~(32'h1 << smci_pkg::BIT_BUSERR))
            | (bankCfg_reg[b] & ~reqData_reg
            & ((32'h1 << smci_pkg::BIT_WPERR) | (32'h1 << smci_pkg::BIT_BUSERR)));
        end
        // Hardware sets come last so they win over a clear
        if (state_reg == smci_pkg::ST_ONE && reqWpErr_reg
            && reqAddr_reg[smci_pkg::SYS_ADDR_W-1:smci_pkg::BANK_LSB] == b) begin
          bankCfg_reg[b][smci_pkg::BIT_WPERR] <= 1'b1;
        end
        if (retract
            && reqAddr_reg[smci_pkg::SYS_ADDR_W-1:smci_pkg::BANK_LSB] == b) begin
          bankCfg_reg[b][smci_pkg::BIT_BUSERR] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Bus responses
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busWait <= 1'b0;
      busError <= 1'b0;
      busLast <= 1'b0;
    end else begin
      busError <= 1'b0;
      busLast <= 1'b0;
      if (accept) begin
        // at least one wait cycle per transfer
        busWait <= 1'b1;
      end else if (state_reg == smci_pkg::ST_ONE) begin
        busWait <= 1'b0;
        busError <= reqWpErr_reg || (reqCfg_reg && !reqRegValid);
      end else if (retract) begin
        busWait <= 1'b0;
        busError <= 1'b1;
        busLast <= 1'b1;
      end else if (accDone) begin
        busWait <= 1'b0;
        // nonburst banks end the burst every transfer
        busLast <= !cfgSel[smci_pkg::BIT_BM];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busDataOut <= '0;
      busDataOe <= 1'b0;
    end else begin
      busDataOe <= 1'b0;
      if (scanTestMode) begin
        busDataOe <= 1'b0;
      end else if (!testDinEn_n) begin
        busDataOut <= extDataIn;
        busDataOe <= 1'b1;
      end else if (state_reg == smci_pkg::ST_ONE && reqCfg_reg
          && !reqWrite_reg) begin
        // drive read data in the completion cycle
        busDataOut <= reqRegValid ? bankCfg_reg[reqIdx] : '0;
        busDataOe <= 1'b1;
      end else if (accDone && !reqWrite_reg) begin
        busDataOut <= extDataIn;
        busDataOe <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // External pins
  // ----------------------------------------
  // latch follows system data while enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      testLatch_reg <= '0;
    end else if (!testDoutLatchEn_n) begin
      testLatch_reg <= busDataIn;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extBusRequest <= 1'b0;
      extAddress <= '0;
      extDataOut <= '0;
      extOutputEnable_n <= 1'b1;
      extWriteEnable_n <= 1'b1;
      extByteLane_n <= smci_pkg::LANES_ALL;
      extLaneDrive_n <= smci_pkg::LANES_ALL;
    end else begin
      // request while a memory access or test takeover runs
      extBusRequest <= testTakeover || state_next == smci_pkg::ST_REQ
        || state_next == smci_pkg::ST_TURN || accNext;
      extAddress <= reqAddr_reg[smci_pkg::EXT_ADDR_W-1:0];
      extDataOut <= !testDoutEn_n ? testLatch_reg : reqData_reg;
      extOutputEnable_n <= !(accNext && !reqWrite_reg);
      extWriteEnable_n <= !(accNext && reqWrite_reg);
      if (!accNext) begin
        extByteLane_n <= smci_pkg::LANES_ALL;
      end else if (reqWrite_reg) begin
        extByteLane_n <= ~laneSel;
      end else begin
        extByteLane_n <= cfgSel[smci_pkg::BIT_READ_LANE_ASSERT] ? smci_pkg::LANES_NONE
          : smci_pkg::LANES_ALL;
      end
      if (scanTestMode) begin
        extLaneDrive_n <= smci_pkg::LANES_ALL;
      end else if (!testDoutEn_n) begin
        extLaneDrive_n <= smci_pkg::LANES_NONE;
      end else if (accNext && reqWrite_reg) begin
        extLaneDrive_n <= ~laneSel;
      end else begin
        extLaneDrive_n <= smci_pkg::LANES_ALL;
      end
    end
  end

  generate
    for (genvar g = 0; g < smci_pkg::NUM_BANKS; g++) begin : gCs
      assign csActive[g] = accNext
        && reqAddr_reg[smci_pkg::SYS_ADDR_W-1:smci_pkg::BANK_LSB] == g;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          bankChipSelect[g] <= 1'b1;
        end else begin
          bankChipSelect[g] <= csPolVec[g] ? csActive[g] : !csActive[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  accept_wait_a:
    assert property (accept |=> busWait)
    else $error("wait not raised after accept");
  retract_resp_a:
    assert property (retract |=> busError && busLast && !busWait)
    else $error("retract not signalled");
  protect_error_a:
    assert property (state_reg == smci_pkg::ST_ONE && reqWpErr_reg |=> busError
      && !busWait && bankCfg_reg[reqAddr_reg[smci_pkg::SYS_ADDR_W-1:
      smci_pkg::BANK_LSB]][smci_pkg::BIT_WPERR])
    else $error("protected write not refused");
  read_lanes_a:
    assert property (!extOutputEnable_n && !$past(accept) |-> extByteLane_n ==
      (cfgSel[smci_pkg::BIT_READ_LANE_ASSERT] ? smci_pkg::LANES_NONE : smci_pkg::LANES_ALL))
    else $error("read byte lanes wrong");
  chip_idle_a:
    assert property (state_reg == smci_pkg::ST_IDLE
      && $past(state_reg) == smci_pkg::ST_IDLE |-> bankChipSelect == ~csPolVec)
    else $error("idle chip select not inactive");
  scan_quiet_a:
    assert property ($past(scanTestMode) |-> !busDataOe
      && extLaneDrive_n == smci_pkg::LANES_ALL)
    else $error("tristate driven in scan mode");
  strobe_grant_a:
    assert property (!extOutputEnable_n || !extWriteEnable_n
      |-> extBusRequest && $past(extBusGrant))
    else $error("strobe without grant");
  test_din_a:
    assert property (!testDinEn_n && !scanTestMode
      |=> busDataOe && busDataOut == $past(extDataIn))
    else $error("test data not driven onto bus");
  wait_extend_a:
    assert property (state_reg == smci_pkg::ST_ACC && extBusGrant
      && cfgSel[smci_pkg::BIT_EXT_WAIT_ENABLE] && waitAsserted && !cntZero
      |=> state_reg == smci_pkg::ST_ACC)
    else $error("access ended while wait asserted");

  cfg_read_c: cover property (state_reg == smci_pkg::ST_ONE && reqCfg_reg
    && !reqWrite_reg ##1 busDataOe);
  mem_write_c: cover property (accDone && reqWrite_reg);
  retract_seen_c: cover property (retract);
  wait_held_c: cover property (waitSeen_reg && state_reg == smci_pkg::ST_ACC);

endmodule

// ---- verification/smci_mem_model.sv ----
// Far-side model: external bus arbiter loopback and a small static memory.
// Assumes byte addresses on extAddress and one word per four bytes.
`timescale 1ns/1ns

module smci_mem_model (
  input wire logic clk,
  input wire logic grantHold,
  input wire logic extBusRequest,
  output logic extBusGrant,
  input wire logic [22:0] extAddress,
  input wire logic [31:0] extDataOut,
  input wire logic [3:0] extLaneDrive_n,
  input wire logic extOutputEnable_n,
  input wire logic extWriteEnable_n,
  input wire logic [3:0] extByteLane_n,
  output logic [31:0] extDataIn,
  output logic extWaitIn
);
  logic [31:0] mem [0:255];
  logic [31:0] lastRead;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 32'h0;
    end
    lastRead = 32'h0;
  end

  // request looped to grant
  // Bench may withhold grant to force a retract
  assign extBusGrant = extBusRequest & ~grantHold;
  // Wait input high: idle for active-low banks, held for active-high ones
  assign extWaitIn = 1'b1;

  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!extWriteEnable_n && !extByteLane_n[i] && !extLaneDrive_n[i]) begin
        mem[extAddress[9:2]][8*i+:8] <= extDataOut[8*i+:8];
      end
    end
    if (!extOutputEnable_n) begin
      lastRead <= extDataIn;
    end
  end

  // released bus shows inverse, never stale data
  assign extDataIn = !extOutputEnable_n ? mem[extAddress[9:2]] : ~lastRead;
endmodule

// ---- verification/static_memory_ctrl_interface_bench.sv ----
// Self-checking bench for the static memory controller core.
// Assumes the far-side model of smci_mem_model beside the core.
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end

module static_memory_ctrl_interface_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [25:0] busAddr = 26'h0;
  logic busWrite = 1'b0;
  logic [1:0] busSize = 2'h2;
  logic cfgRegionSelect = 1'b0;
  logic memRegionSelect = 1'b0;
  logic [31:0] busDataIn = 32'h0;
  logic [31:0] busDataOut, extDataIn, extDataOut;
  logic busDataOe, busWait, busError, busLast, extBusRequest, extBusGrant;
  logic testTakeover = 1'b0;
  logic testDinEn_n = 1'b1;
  logic testDoutEn_n = 1'b1;
  logic testDoutLatchEn_n = 1'b1;
  logic endianSelect = 1'b0;
  logic scanTestMode = 1'b0;
  logic grantHold = 1'b0;
  logic extWaitIn, extOutputEnable_n, extWriteEnable_n;
  logic [22:0] extAddress;
  logic [3:0] extLaneDrive_n, extByteLane_n, lanes;
  logic [7:0] bankChipSelect;
  logic [31:0] rdData, d, refMem [0:255];
  logic rdErr, rdLast;
  logic [25:0] a;
  int miscompares = 0;
  int comparisons = 0;
  int rdCycles = 0;

  always #5 clk = ~clk;

  smci_core #(.GRANT_WAIT(8'h04)) i_dut (.clk(clk), .rst_n(rst_n),
    .busAddr(busAddr), .busWrite(busWrite), .busSize(busSize),
    .cfgRegionSelect(cfgRegionSelect), .memRegionSelect(memRegionSelect),
    .busDataIn(busDataIn), .busDataOut(busDataOut), .busDataOe(busDataOe),
    .busWait(busWait), .busError(busError), .busLast(busLast),
    .testTakeover(testTakeover), .testDinEn_n(testDinEn_n),
    .testDoutEn_n(testDoutEn_n), .testDoutLatchEn_n(testDoutLatchEn_n),
    .endianSelect(endianSelect), .scanTestMode(scanTestMode),
    .extBusRequest(extBusRequest), .extBusGrant(extBusGrant),
    .extDataIn(extDataIn), .extWaitIn(extWaitIn), .extDataOut(extDataOut),
    .extAddress(extAddress), .extLaneDrive_n(extLaneDrive_n),
    .bankChipSelect(bankChipSelect), .extOutputEnable_n(extOutputEnable_n),
    .extWriteEnable_n(extWriteEnable_n), .extByteLane_n(extByteLane_n));

  smci_mem_model i_mem (.clk(clk), .grantHold(grantHold),
    .extBusRequest(extBusRequest), .extBusGrant(extBusGrant),
    .extAddress(extAddress), .extDataOut(extDataOut),
    .extLaneDrive_n(extLaneDrive_n), .extOutputEnable_n(extOutputEnable_n),
    .extWriteEnable_n(extWriteEnable_n), .extByteLane_n(extByteLane_n),
    .extDataIn(extDataIn), .extWaitIn(extWaitIn));

  task automatic test_done();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One-cycle select, then bounded wait for the completion cycle
  task automatic xfer(input logic cfg, input logic wr, input logic [25:0] ad,
                      input logic [1:0] sz, input logic [31:0] wd);
    int n;
    @(posedge clk);
    cfgRegionSelect <= cfg;
    memRegionSelect <= !cfg;
    busWrite <= wr;
    busAddr <= ad;
    busSize <= sz;
    busDataIn <= wd;
    @(posedge clk);
    cfgRegionSelect <= 1'b0;
    memRegionSelect <= 1'b0;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      #1;
      if (busWait === 1'b0) break;
    end
    if (n == 200) begin
      miscompares++;
      test_done();
    end
    rdData = busDataOut;
    rdErr = busError;
    rdLast = busLast;
    rdCycles = n;
  endtask

  initial begin
    void'($urandom(32'hC9A0));
    for (int i = 0; i < 256; i++) begin
      refMem[i] = 32'h0;
    end
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // ------------------------------------------------
    // Register region
    // ------------------------------------------------
    for (int b = 0; b < 8; b++) begin
      xfer(1'b1, 1'b0, 26'(b * 4), 2'h2, 32'h0);
      `CHK(rdData, smci_pkg::CFG_RESET)
    end
    xfer(1'b1, 1'b1, 26'h0C, 2'h2, 32'hFFFFFFFF);
    xfer(1'b1, 1'b0, 26'h0C, 2'h2, 32'h0);
    `CHK(rdData, 32'h3CE0FFEF)
    xfer(1'b1, 1'b0, 26'h20, 2'h2, 32'h0);
    `CHK({rdErr, rdData}, {1'b1, 32'h0})
    xfer(1'b1, 1'b1, 26'h00, 2'h2, 32'h10000000);
    xfer(1'b1, 1'b1, 26'h08, 2'h2, 32'h14000000);
    $display("test registers done");
    // ------------------------------------------------
    // Memory sizes and endianness
    // ------------------------------------------------
    for (int e = 0; e < 2; e++) begin
      for (int s = 0; s < 3; s++) begin
        endianSelect <= e[0];
        a = 26'($urandom) & 26'h3FF;
        d = $urandom;
        if (s == 0) begin
          lanes = e[0] ? 4'h8 >> a[1:0] : 4'h1 << a[1:0];
        end else if (s == 1) begin
          lanes = (a[1] ^ e[0]) ? 4'hC : 4'h3;
        end else begin
          lanes = 4'hF;
        end
        for (int i = 0; i < 4; i++) begin
          if (lanes[i]) refMem[a[9:2]][8*i+:8] = d[8*i+:8];
        end
        xfer(1'b0, 1'b1, a, s[1:0], d);
        `CHK({rdErr, rdLast}, 2'b01)
        `CHK(extAddress, a[22:0])
        // Bank 3 was made active-high by the all-ones register write
        `CHK(bankChipSelect, 8'hF7)
        xfer(1'b0, 1'b0, a, 2'h2, 32'h0);
        `CHK(rdData, refMem[a[9:2]])
        `CHK(busDataOe, 1'b1)
      end
    end
    // Bank 0: wait enabled, active-high wait, read lanes on, WST1 of 3
    xfer(1'b1, 1'b1, 26'h00, 2'h2, 32'h10600460);
    xfer(1'b0, 1'b0, 26'h00, 2'h2, 32'h0);
    `CHK(rdData, refMem[0])
    // Wait held: one turn and WST1+1 access cycles after the request cycle
    `CHK(rdCycles, 5)
    $display("test memory done");
    // ------------------------------------------------
    // Write protect, retract and error flags
    // ------------------------------------------------
    xfer(1'b0, 1'b1, 26'h1000000, 2'h2, 32'h5A5A5A5A);
    `CHK(rdErr, 1'b1)
    xfer(1'b1, 1'b0, 26'h08, 2'h2, 32'h0);
    `CHK(rdData[25], 1'b1)
    grantHold <= 1'b1;
    xfer(1'b0, 1'b0, 26'h10, 2'h2, 32'h0);
    `CHK({rdErr, rdLast}, 2'b11)
    grantHold <= 1'b0;
    xfer(1'b1, 1'b0, 26'h00, 2'h2, 32'h0);
    `CHK(rdData[24], 1'b1)
    xfer(1'b1, 1'b1, 26'h00, 2'h2, 32'h11000000);
    xfer(1'b1, 1'b0, 26'h00, 2'h2, 32'h0);
    `CHK(rdData, 32'h10000000)
    $display("test errors done");
    // ------------------------------------------------
    // Test bus, latch and scan
    // ------------------------------------------------
    @(posedge clk);
    testDinEn_n <= 1'b0;
    testDoutLatchEn_n <= 1'b0;
    busDataIn <= 32'hC3A5965A;
    @(posedge clk);
    testDoutLatchEn_n <= 1'b1;
    busDataIn <= 32'h0F0F0F0F;
    testDoutEn_n <= 1'b0;
    @(posedge clk);
    #1;
    `CHK({busDataOe, busDataOut}, {1'b1, extDataIn})
    @(posedge clk);
    #1;
    `CHK({extLaneDrive_n, extDataOut}, {4'h0, 32'hC3A5965A})
    scanTestMode <= 1'b1;
    @(posedge clk);
    #1;
    `CHK({busDataOe, extLaneDrive_n}, {1'b0, 4'hF})
    scanTestMode <= 1'b0;
    testDinEn_n <= 1'b1;
    testDoutEn_n <= 1'b1;
    testTakeover <= 1'b1;
    cfgRegionSelect <= 1'b1;
    @(posedge clk);
    cfgRegionSelect <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK({busWait, extBusRequest}, 2'b01)
    testTakeover <= 1'b0;
    $display("test takeover done");
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule
